/* hdl/vccd_regs.svh */
// Functional notes
// [RL1] first calibration: host writes start bit one
// [RL2] later calibration: clear, commit, set, commit
// [RL3] writes take effect only on update commit
// [RL4] done status bit reads one after calibration
// [RL5] cal clock is reference over R times div
// [RL6] calibration lasts 4400 calibration clock cycles
// [RL7] outputs held synchronized during calibration
// [RL8] release sync at end, then close loop
// [RL9] host programs valid loop before calibration
// [RL10] reference clock must run throughout calibration
// [RL11] no automatic calibration on divider changes
// [RL12] host recalibrates after loop divider changes
// [RL13] channel divides 2 to 32, bypass one
// [RL14] high N+1 cycles, low M+1 cycles
// [RL15] duty correction for odd when M=N+1
// [RL16] coarse phase delay up to 31 cycles
// [RL17] start level selectable high or low
// [RL18] source select 00,01,10; 11 not allowed
// [RL19] prescale divider divides by 2 to 6
// [RL20] host routes fast sources through prescaler
// [RL21] duty correction on by default, per-channel off
// [RL22] done bit zero while calibration runs
`ifndef VCCD_REGS_SVH
`define VCCD_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define VCCD_CAL_CONTROL_ADDR 10'h018
`define VCCD_READBACK_ADDR 10'h01F
`define VCCD_SRC_SELECT_ADDR 10'h1E1
`define VCCD_UPDATE_ADDR 10'h232
`define VCCD_VCODIV_ADDR 10'h1E0
`define VCCD_CH0_COUNT_ADDR 10'h190
`define VCCD_CH0_PHASE_ADDR 10'h191
`define VCCD_CH0_CTRL_ADDR 10'h192
`define VCCD_CH_STRIDE 10'h003
// ****************************************
// field positions
// ****************************************
`define VCCD_CAL_START_BIT 0
`define VCCD_CAL_DIV_LSB 1
`define VCCD_CAL_DONE_BIT 6
`define VCCD_UPDATE_BIT 0
`define VCCD_BYPASS_BIT 7
`define VCCD_START_HIGH_BIT 5
`define VCCD_DCC_OFF_BIT 0
// ****************************************
// reset values and timing
// ****************************************
`define VCCD_CAL_CYCLES 13'd4400
`define VCCD_RESET_BYTE 8'h00
`define VCCD_VCODIV_RESET 3'h0
`endif

/* hdl/vccd_pkg.sv */
package vccd_pkg;
   typedef enum logic [1:0] {
      VCCD_SRC_EXT_DIV,
      VCCD_SRC_EXT_DIRECT,
      VCCD_SRC_VCO_DIV,
      VCCD_SRC_BAD
   } vccd_src_type;
   typedef enum logic [1:0] {
      VCCD_CAL_IDLE,
      VCCD_CAL_RUN,
      VCCD_CAL_CLOSE
   } vccd_cal_state_type;
   typedef enum logic [1:0] {
      VCCD_HOST_IDLE,
      VCCD_HOST_WRITE,
      VCCD_HOST_READ
   } vccd_host_state_type;
endpackage

/* hdl/vccd_if.sv */
`timescale 1ns/100ps
interface vccd_if;
   logic wr_en;
   logic rd_en;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   modport device (input wr_en, input rd_en, input addr, input wdata,
      output rdata, output rvalid);
   modport host (output wr_en, output rd_en, output addr, output wdata,
      input rdata, input rvalid);
endinterface

/* hdl/vccd_device.sv */
`timescale 1ns/100ps
`include "vccd_regs.svh"
module vccd_device import vccd_pkg::*; #(
   parameter int CHANNELS = 3
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // register port
   vccd_if.device bus,
   // clocks to divide (pins, sampled twice)
   input wire logic vco_clk_in,
   input wire logic ext_clk_in,
   input wire logic pfd_tick_in,
   // status and outputs
   output logic sync_hold_out,
   output logic loop_closed_out,
   output logic [CHANNELS-1:0] chan_out
);
   typedef struct packed {
      logic [7:0] cal_buf;
      logic [7:0] cal_act;
      logic [1:0] src_buf;
      logic [1:0] src_act;
      logic [2:0] vdiv_buf;
      logic [2:0] vdiv_act;
      logic [CHANNELS-1:0][7:0] cnt_buf;
      logic [CHANNELS-1:0][7:0] cnt_act;
      logic [CHANNELS-1:0][7:0] ph_buf;
      logic [CHANNELS-1:0][7:0] ph_act;
      logic [CHANNELS-1:0][7:0] ctl_buf;
      logic [CHANNELS-1:0][7:0] ctl_act;
      vccd_cal_state_type cal_state;
      logic [12:0] cal_cnt;
      logic [2:0] caldiv_cnt;
      logic cal_done;
      logic sync_hold;
      logic loop_closed;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] pre_cnt;
      logic pre_out;
      logic pre_last;
      logic [CHANNELS-1:0][4:0] ch_cnt;
      logic [CHANNELS-1:0][4:0] ph_cnt;
      logic [CHANNELS-1:0] ch_lvl;
      logic [CHANNELS-1:0] ch_out;
      logic [7:0] rdata;
      logic rvalid;
   } vccd_state_type;
   vccd_state_type st_reg, st_next;
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [2:0] caldiv_top(input logic [1:0] f);
      // field 0..3 divides by 1,2,4,8
      case (f)
         2'h0: caldiv_top = 3'h0;
         2'h1: caldiv_top = 3'h1;
         2'h2: caldiv_top = 3'h3;
         default: caldiv_top = 3'h7;
      endcase
   endfunction
   function automatic logic [9:0] ch_addr(input logic [9:0] base,
         input int i);
      ch_addr = base + 10'(i) * `VCCD_CH_STRIDE;
   endfunction
   logic src_clk, div_in;
   always_comb begin
      logic pfd_rise, src_rise, in_rise, hi, done_ph, cal_go;
      logic [4:0] lim, n, m;
      logic [2:0] vtop;
      st_next = st_reg;
      pfd_rise = 1'b0;
      src_rise = 1'b0;
      in_rise = 1'b0;
      hi = 1'b0;
      done_ph = 1'b0;
      cal_go = 1'b0;
      lim = 5'h0;
      n = 5'h0;
      m = 5'h0;
      vtop = 3'h0;
      st_next.s1 = {pfd_tick_in, ext_clk_in, vco_clk_in};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.rvalid = 1'b0;
      // ****************************************
      // register port
      // ****************************************
      if (bus.wr_en) begin
         case (bus.addr)
            `VCCD_CAL_CONTROL_ADDR: st_next.cal_buf = bus.wdata;
            `VCCD_SRC_SELECT_ADDR: st_next.src_buf = bus.wdata[1:0];
            `VCCD_VCODIV_ADDR: st_next.vdiv_buf = bus.wdata[2:0];
            `VCCD_UPDATE_ADDR: begin
               if (bus.wdata[`VCCD_UPDATE_BIT]) begin
                  st_next.cal_act = st_reg.cal_buf; // [RL3]
                  // rising committed start bit only; no auto start
                  if (st_reg.cal_buf[`VCCD_CAL_START_BIT] &&
                      !st_reg.cal_act[`VCCD_CAL_START_BIT]) begin
                     st_next.cal_state = VCCD_CAL_RUN; // [RL1] [RL2] [RL11]
                     cal_go = 1'b1;
                     st_next.cal_cnt = 13'h0;
                     st_next.caldiv_cnt = 3'h0;
                     st_next.cal_done = 1'b0; // [RL22]
                     st_next.sync_hold = 1'b1; // [RL7]
                     st_next.loop_closed = 1'b0;
                  end
                  // code 11 is refused; previous source stays
                  if (st_reg.src_buf != 2'h3) begin
                     st_next.src_act = st_reg.src_buf; // [RL18]
                  end
                  st_next.vdiv_act = st_reg.vdiv_buf;
                  st_next.cnt_act = st_reg.cnt_buf;
                  st_next.ph_act = st_reg.ph_buf;
                  st_next.ctl_act = st_reg.ctl_buf;
               end
            end
            default: begin
            end
         endcase
         for (int i = 0; i < CHANNELS; i++) begin
            if (bus.addr == ch_addr(`VCCD_CH0_COUNT_ADDR, i)) begin
               st_next.cnt_buf[i] = bus.wdata;
            end
            if (bus.addr == ch_addr(`VCCD_CH0_PHASE_ADDR, i)) begin
               st_next.ph_buf[i] = bus.wdata;
            end
            if (bus.addr == ch_addr(`VCCD_CH0_CTRL_ADDR, i)) begin
               st_next.ctl_buf[i] = bus.wdata;
            end
         end
      end
      if (bus.rd_en) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = 8'h00;
         case (bus.addr)
            `VCCD_CAL_CONTROL_ADDR: st_next.rdata = st_reg.cal_buf;
            `VCCD_READBACK_ADDR:
               st_next.rdata[`VCCD_CAL_DONE_BIT] = st_reg.cal_done; // [RL4]
            `VCCD_SRC_SELECT_ADDR: st_next.rdata = {6'h0, st_reg.src_buf};
            `VCCD_VCODIV_ADDR: st_next.rdata = {5'h0, st_reg.vdiv_buf};
            default: begin
            end
         endcase
         for (int i = 0; i < CHANNELS; i++) begin
            if (bus.addr == ch_addr(`VCCD_CH0_COUNT_ADDR, i)) begin
               st_next.rdata = st_reg.cnt_buf[i];
            end
            if (bus.addr == ch_addr(`VCCD_CH0_PHASE_ADDR, i)) begin
               st_next.rdata = st_reg.ph_buf[i];
            end
            if (bus.addr == ch_addr(`VCCD_CH0_CTRL_ADDR, i)) begin
               st_next.rdata = st_reg.ctl_buf[i];
            end
         end
      end
      // ****************************************
      // calibration sequencer
      // ****************************************
      pfd_rise = st_reg.s2[2] && !st_reg.s3[2];
      // a start in this cycle outranks the old run, else it is lost
      case (cal_go ? VCCD_CAL_IDLE : st_reg.cal_state)
         VCCD_CAL_RUN: begin
            if (pfd_rise) begin
               // one cal clock per R output times cal divide
               if (st_reg.caldiv_cnt >=
                   caldiv_top(st_reg.cal_act[`VCCD_CAL_DIV_LSB +: 2])) begin
                  st_next.caldiv_cnt = 3'h0; // [RL5]
                  st_next.cal_cnt = st_reg.cal_cnt + 13'h1;
                  if (st_reg.cal_cnt == `VCCD_CAL_CYCLES - 13'h1) begin
                     st_next.cal_state = VCCD_CAL_CLOSE; // [RL6]
                     st_next.sync_hold = 1'b0; // [RL8]
                  end
               end else begin
                  st_next.caldiv_cnt = st_reg.caldiv_cnt + 3'h1;
               end
            end
         end
         VCCD_CAL_CLOSE: begin
            st_next.loop_closed = 1'b1; // [RL8]
            st_next.cal_done = 1'b1; // [RL4]
            st_next.cal_state = VCCD_CAL_IDLE;
         end
         default: begin
         end
      endcase
      // ****************************************
      // source select and prescaler
      // ****************************************
      src_clk = (st_reg.src_act == VCCD_SRC_VCO_DIV) ? st_reg.s2[0] :
         st_reg.s2[1];
      src_rise = src_clk && !((st_reg.src_act == VCCD_SRC_VCO_DIV) ?
         st_reg.s3[0] : st_reg.s3[1]);
      // field 0..4 divides by 2..6, larger codes clamp at 6
      vtop = (st_reg.vdiv_act > 3'h4) ? 3'h5 : st_reg.vdiv_act + 3'h1;
      st_next.pre_last = st_reg.pre_out;
      if (src_rise) begin
         if (st_reg.pre_cnt >= vtop) begin
            st_next.pre_cnt = 3'h0; // [RL19]
         end else begin
            st_next.pre_cnt = st_reg.pre_cnt + 3'h1;
         end
         st_next.pre_out = (st_next.pre_cnt < 3'((vtop + 3'h1) >> 1));
      end
      div_in = (st_reg.src_act == VCCD_SRC_EXT_DIRECT) ? src_clk :
         st_reg.pre_out;
      in_rise = (st_reg.src_act == VCCD_SRC_EXT_DIRECT) ? src_rise :
         (st_reg.pre_out && !st_reg.pre_last);
      // ****************************************
      // channel dividers
      // ****************************************
      for (int i = 0; i < CHANNELS; i++) begin
         n = {1'b0, st_reg.cnt_act[i][3:0]};
         m = {1'b0, st_reg.cnt_act[i][7:4]};
         if (st_reg.sync_hold) begin
            // static level is the start level
            st_next.ch_lvl[i] =
               st_reg.ctl_act[i][`VCCD_START_HIGH_BIT]; // [RL7] [RL17]
            st_next.ch_cnt[i] = 5'h0;
            st_next.ph_cnt[i] = st_reg.ph_act[i][4:0]; // [RL16]
         end else if (in_rise) begin
            done_ph = (st_reg.ph_cnt[i] == 5'h0);
            if (!done_ph) begin
               st_next.ph_cnt[i] = st_reg.ph_cnt[i] - 5'h1; // [RL16]
            end else begin
               hi = st_reg.ch_lvl[i];
               // correction moves the odd extra cycle to the high phase when M = N + 1
               if (!st_reg.ctl_act[i][`VCCD_DCC_OFF_BIT] &&
                   m == n + 5'h1) begin
                  lim = hi ? n + 5'h1 : n; // [RL15] [RL21]
               end else begin
                  lim = hi ? n : m; // [RL14]
               end
               if (st_reg.ch_cnt[i] >= lim) begin
                  st_next.ch_cnt[i] = 5'h0; // [RL13]
                  st_next.ch_lvl[i] = !st_reg.ch_lvl[i];
               end else begin
                  st_next.ch_cnt[i] = st_reg.ch_cnt[i] + 5'h1;
               end
            end
         end
         // bypass passes the divider input straight through
         st_next.ch_out[i] = st_reg.ph_act[i][`VCCD_BYPASS_BIT] ?
            (div_in && !st_reg.sync_hold) : st_reg.ch_lvl[i]; // [RL13]
      end
      if (reset_in) begin
         st_next = '0;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      st_reg <= st_next;
   end
   assign bus.rdata = st_reg.rdata;
   assign bus.rvalid = st_reg.rvalid;
   assign sync_hold_out = st_reg.sync_hold;
   assign loop_closed_out = st_reg.loop_closed;
   assign chan_out = st_reg.ch_out;
endmodule // vccd_device

/* hdl/vccd_host.sv */
`timescale 1ns/100ps
`include "vccd_regs.svh"
module vccd_host import vccd_pkg::*; (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // register port
   vccd_if.host bus,
   // user command side
   input wire logic cmd_write_in,
   input wire logic cmd_read_in,
   input wire logic [9:0] cmd_addr_in,
   input wire logic [7:0] cmd_data_in,
   output logic cmd_busy_out,
   output logic [7:0] cmd_rdata_out,
   output logic cmd_rvalid_out
);
   typedef struct packed {
      vccd_host_state_type state;
      logic wr_en;
      logic rd_en;
      logic [9:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic rvalid;
   } vccd_hst_type;
   vccd_hst_type st_reg, st_next;
   // the host is a plain access pump; calibration order and loop
   // settings are the caller's duty  [RL9] [RL10] [RL12] [RL20]
   always_comb begin
      st_next = st_reg;
      st_next.wr_en = 1'b0;
      st_next.rd_en = 1'b0;
      st_next.rvalid = 1'b0;
      case (st_reg.state)
         VCCD_HOST_IDLE: begin
            if (cmd_write_in) begin
               st_next.wr_en = 1'b1;
               st_next.addr = cmd_addr_in;
               st_next.wdata = cmd_data_in;
               st_next.state = VCCD_HOST_WRITE;
            end else if (cmd_read_in) begin
               st_next.rd_en = 1'b1;
               st_next.addr = cmd_addr_in;
               st_next.state = VCCD_HOST_READ;
            end
         end
         VCCD_HOST_WRITE: st_next.state = VCCD_HOST_IDLE;
         VCCD_HOST_READ: begin
            if (bus.rvalid) begin
               st_next.rdata = bus.rdata;
               st_next.rvalid = 1'b1;
               st_next.state = VCCD_HOST_IDLE;
            end
         end
         default: st_next.state = VCCD_HOST_IDLE;
      endcase
      if (reset_in) begin
         st_next = '0;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      st_reg <= st_next;
   end
   assign bus.wr_en = st_reg.wr_en;
   assign bus.rd_en = st_reg.rd_en;
   assign bus.addr = st_reg.addr;
   assign bus.wdata = st_reg.wdata;
   assign cmd_busy_out = (st_reg.state != VCCD_HOST_IDLE);
   assign cmd_rdata_out = st_reg.rdata;
   assign cmd_rvalid_out = st_reg.rvalid;
endmodule // vccd_host

/* tb/vccd_chk.sv */
`timescale 1ns/100ps
// ****************************************
// register bus checks
// ****************************************
module vccd_chk (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // register bus
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);
   sequence s_read;
      rd_en ##1 rvalid;
   endsequence
   sequence s_status;
      rd_en && addr == 10'h01F;
   endsequence
   a_read_answered: assert property (rd_en |-> s_read)
      else $error("read not answered next cycle");
   a_answer_has_cause: assert property (rvalid |-> $past(rd_en))
      else $error("answer without a read");
   a_answer_one_cycle: assert property (rvalid |=> !rvalid)
      else $error("answer longer than one cycle");
   a_status_bit_only: assert property (
      s_status |=> (rdata & 8'hBF) == 8'h00)
      else $error("status reads bits other than done");
   a_unmapped_reads_zero: assert property (
      rd_en && addr == 10'h3FF |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!rvalid |-> $stable(rdata))
      else $error("read data moved without an answer");
   a_no_mixed_cmd: assert property (!(wr_en && rd_en))
      else $error("write and read together");
   a_write_single: assert property (wr_en |=> !wr_en)
      else $error("write strobe longer than one cycle");
endmodule // vccd_chk

/* tb/vccd_tb_top.sv */
`timescale 1ns/100ps
`include "vccd_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
// ****************************************
// bench top
// ****************************************
module vccd_tb_top;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic vco_clk_in = 1'b0;
   logic ext_clk_in = 1'b0;
   logic pfd_tick_in = 1'b0;
   logic cmd_write_in = 1'b0;
   logic cmd_read_in = 1'b0;
   logic [9:0] cmd_addr_in = 10'h000;
   logic [7:0] cmd_data_in = 8'h00;
   logic cmd_busy_out, cmd_rvalid_out, sync_hold_out, loop_closed_out;
   logic [7:0] cmd_rdata_out, rd;
   logic [2:0] chan_out;
   logic [2:0] ph = 3'h0;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   // src, prescale, count, ctrl, high, low (system cycles)
   logic [47:0] rows [6] = '{48'h01_00_31_01_08_10, 48'h00_00_31_01_10_20,
      48'h02_04_00_01_30_30, 48'h01_00_31_80_02_02,
      48'h01_00_FF_01_40_40, 48'h03_00_FF_01_40_40};
   vccd_if i_vccd_if ();
   vccd_device #(.CHANNELS(3)) i_vccd_device (.clk_sys_in(clk_sys_in),
      .reset_in(reset_in), .bus(i_vccd_if), .vco_clk_in(vco_clk_in),
      .ext_clk_in(ext_clk_in), .pfd_tick_in(pfd_tick_in),
      .sync_hold_out(sync_hold_out), .loop_closed_out(loop_closed_out),
      .chan_out(chan_out));
   vccd_host i_vccd_host (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .bus(i_vccd_if), .cmd_write_in(cmd_write_in),
      .cmd_read_in(cmd_read_in), .cmd_addr_in(cmd_addr_in),
      .cmd_data_in(cmd_data_in), .cmd_busy_out(cmd_busy_out),
      .cmd_rdata_out(cmd_rdata_out), .cmd_rvalid_out(cmd_rvalid_out));
   vccd_chk i_vccd_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .wr_en(i_vccd_if.wr_en), .rd_en(i_vccd_if.rd_en),
      .addr(i_vccd_if.addr), .wdata(i_vccd_if.wdata),
      .rdata(i_vccd_if.rdata), .rvalid(i_vccd_if.rvalid));
   always #50 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) cyc <= cyc + 1;
   // pins are sampled twice, so keep them four cycles per period at least
   always @(negedge clk_sys_in) begin
      ph <= ph + 3'h1;
      ext_clk_in <= ph[1];
      pfd_tick_in <= ph[1];
      vco_clk_in <= ph[2];
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task report_and_stop;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task tmo;
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop();
   endtask
   task host_wr(input logic [9:0] a, input logic [7:0] d);
      int n;
      @(negedge clk_sys_in);
      cmd_addr_in = a;
      cmd_data_in = d;
      cmd_write_in = 1'b1;
      @(negedge clk_sys_in);
      cmd_write_in = 1'b0;
      n = 0;
      while (cmd_busy_out !== 1'b0) begin
         if (++n > 20) tmo();
         @(negedge clk_sys_in);
      end
   endtask
   task rd_chk(input logic [9:0] a, input logic [7:0] e);
      int n;
      @(negedge clk_sys_in);
      cmd_addr_in = a;
      cmd_read_in = 1'b1;
      @(negedge clk_sys_in);
      cmd_read_in = 1'b0;
      n = 0;
      while (cmd_rvalid_out !== 1'b1) begin
         if (++n > 20) tmo();
         @(negedge clk_sys_in);
      end
      rd = cmd_rdata_out;
      `CHK(rd, e)
   endtask
   task commit;
      host_wr(`VCCD_UPDATE_ADDR, 8'h01);
   endtask
   task wait_sync(input logic lvl, input int lim);
      int n;
      n = 0;
      while (sync_hold_out !== lvl) begin
         if (++n > lim) tmo();
         @(negedge clk_sys_in);
      end
   endtask
   task edge_wait(input logic lvl, input int b = 0);
      int n;
      n = 0;
      while (chan_out[b] !== lvl) begin
         if (++n > 300) tmo();
         @(negedge clk_sys_in);
      end
   endtask
   // skips two periods, as the divider keeps its count across a commit
   task meas(output int hi, output int lo);
      int t;
      edge_wait(1'b0);
      edge_wait(1'b1);
      edge_wait(1'b0);
      edge_wait(1'b1);
      t = cyc;
      edge_wait(1'b0);
      hi = cyc - t;
      t = cyc;
      edge_wait(1'b1);
      lo = cyc - t;
   endtask
   task cal_run(input logic [7:0] ctl, input int exp, input logic [2:0] lv);
      int t0;
      logic [2:0] c;
      host_wr(`VCCD_CAL_CONTROL_ADDR, ctl);
      commit();
      wait_sync(1'b1, 20);
      t0 = cyc;
      `CHK(loop_closed_out, 1'b0)
      rd_chk(`VCCD_READBACK_ADDR, 8'h00);
      c = chan_out;
      `CHK(c, lv)
      repeat (50) @(negedge clk_sys_in);
      `CHK(chan_out, c)
      wait_sync(1'b0, 40000);
      `CHK((cyc - t0 >= exp - 8) && (cyc - t0 <= exp + 8), 1'b1)
      @(negedge clk_sys_in);
      `CHK(loop_closed_out, 1'b1)
      rd_chk(`VCCD_READBACK_ADDR, 8'h40);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      rd_chk(`VCCD_CAL_CONTROL_ADDR, 8'h00);
      rd_chk(`VCCD_READBACK_ADDR, 8'h00);
      rd_chk(`VCCD_SRC_SELECT_ADDR, 8'h00);
      rd_chk(10'h3FF, 8'h00);
      $display("reset test done");
   endtask
   task t_cal;
      int t;
      host_wr(`VCCD_CAL_CONTROL_ADDR, 8'h01);
      repeat (10) @(negedge clk_sys_in);
      `CHK(sync_hold_out, 1'b0)
      cal_run(8'h01, 17600, 3'h0);
      host_wr(`VCCD_CH0_COUNT_ADDR, 8'h11);
      commit();
      repeat (10) @(negedge clk_sys_in);
      `CHK(sync_hold_out, 1'b0)
      // channels 1 and 2 start high, held back 7 and 4 input cycles
      host_wr(`VCCD_CH0_PHASE_ADDR + `VCCD_CH_STRIDE, 8'h07);
      host_wr(`VCCD_CH0_CTRL_ADDR + `VCCD_CH_STRIDE, 8'h20);
      host_wr(`VCCD_CH0_PHASE_ADDR + 10'h006, 8'h04);
      host_wr(`VCCD_CH0_CTRL_ADDR + 10'h006, 8'h20);
      host_wr(`VCCD_CAL_CONTROL_ADDR, 8'h00);
      commit();
      cal_run(8'h03, 35200, 3'h6);
      // divider input is the pin over two: eight system cycles each
      edge_wait(1'b0, 2);
      t = cyc;
      edge_wait(1'b0, 1);
      `CHK(cyc - t, 24)
      $display("calibration test done");
   endtask
   task t_div;
      logic [47:0] r;
      int hi, lo;
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         host_wr(`VCCD_SRC_SELECT_ADDR, r[47:40]);
         host_wr(`VCCD_VCODIV_ADDR, r[39:32]);
         host_wr(`VCCD_CH0_COUNT_ADDR, r[31:24]);
         // bypass lives in the phase byte, so ctrl bit 7 goes there
         host_wr(`VCCD_CH0_PHASE_ADDR, {r[23], 7'h00});
         host_wr(`VCCD_CH0_CTRL_ADDR, r[23:16]);
         commit();
         meas(hi, lo);
         `CHK(hi, int'(r[15:8]))
         `CHK(lo, int'(r[7:0]))
      end
      $display("divider test done");
   endtask
   task t_dcc;
      int hi, lo;
      host_wr(`VCCD_SRC_SELECT_ADDR, 8'h01);
      host_wr(`VCCD_CH0_COUNT_ADDR, 8'h21);
      host_wr(`VCCD_CH0_CTRL_ADDR, 8'h00);
      commit();
      meas(hi, lo);
      `CHK(hi + lo, 20)
      `CHK(hi > 8, 1'b1)
      host_wr(`VCCD_CH0_CTRL_ADDR, 8'h01);
      commit();
      meas(hi, lo);
      `CHK(hi, 8)
      $display("duty test done");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      reset_in = 1'b0;
      t_reset();
      t_cal();
      t_div();
      t_dcc();
      report_and_stop();
   end
endmodule // vccd_tb_top
